// >>> rtl/bertc_ctrl.v
`include "bertc_consts.vh"
`default_nettype none

// Notes on behaviour
// R1: a rising latch strobe copies internal bit and error counts to the readable counts and clears the internal ones.
// R2: the latch register bit is ORed with its pin and must go low and high again for every further latch.
// R3: the generated pattern is corrupted at regular intervals chosen by the three-bit rate field.
// R4: software may insert errors at any moment with the single error bit, independent of the rate field.
// R5: each rising edge of the single error bit corrupts exactly one transmitted bit.
// R6: with transmit invert set every transmitted bit is inverted, otherwise sent unchanged.
// R7: with receive invert set every received bit is inverted before checking, otherwise used as is.
// R8: software writes zero to the two top bits of the error insertion register.
// R9: one pattern control register holds generation, reception, synchronizer and counter settings.
// R10: rate code 000 inserts nothing and codes 001 to 111 give one error in ten up to one in ten million.
// R11: pattern type zero repeats the user pattern and one produces a pseudorandom sequence.
// R12: the zero-suppressed sequence needs zero suppression, pseudorandom mode, tap 0x10 and length 0x13.
// R13: a rising load strobe, register bit ORed with pin, loads the generator from the seed.
// R14: auto sync reacquires on its own and a rising resync bit always restarts synchronization.
module bertc_ctrl (
    // clock and reset
    input wire clock,
    input wire rst,
    // host parallel port
    input wire [3:0] addr,
    input wire [7:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rd_data,
    // strobe pins
    input wire load_pattern_pin,
    input wire latch_counts_pin,
    input wire rx_latch_pin,
    // serial data pins
    output reg tx_data,
    input wire rx_data_pin,
    // pattern setup from seed, length and tap registers
    input wire [31:0] pattern_seed,
    input wire [4:0] pattern_length,
    input wire [4:0] tap_select,
    // count and capture results
    output reg [31:0] bit_count,
    output reg [31:0] error_count,
    output reg [31:0] pattern_receive,
    output wire in_sync
);

    localparam ST_HUNT = 2'b01;
    localparam ST_LOCK = 2'b10;

    // pick one bit of a 32-bit vector
    function bit_at;
        input [31:0] vec;
        input [4:0] idx;
        begin
            bit_at = vec[idx];
        end
    endfunction

    reg [7:0] pattern_control_r;
    reg [5:0] error_insertion_r;
    reg load_prev_r;
    reg latch_prev_r;
    reg rxl_prev_r;
    reg resync_prev_r;
    reg single_prev_r;
    reg [31:0] gen_r;
    reg [3:0] zrun_r;
    reg [31:0] rxsr_r;
    reg [1:0] state_r;
    reg [5:0] match_r;
    reg [5:0] win_r;
    reg [3:0] win_err_r;
    reg [31:0] bitcnt_r;
    reg [31:0] errcnt_r;
    wire load_pin_s;
    wire latch_pin_s;
    wire rxl_pin_s;
    wire rx_pin_s;
    wire [7:0] carry;

    // pin synchronisers
    bertc_pin_sync u_load (.clock(clock), .rst(rst), .pin(load_pattern_pin), .level(load_pin_s));
    bertc_pin_sync u_latch (.clock(clock), .rst(rst), .pin(latch_counts_pin), .level(latch_pin_s));
    bertc_pin_sync u_rxl (.clock(clock), .rst(rst), .pin(rx_latch_pin), .level(rxl_pin_s));
    assign rx_pin_s = rx_data_pin; // same-clock data, a filter would drop single bits

    // strobe levels, register bit ORed with pin
    wire load_lvl = pattern_control_r[`BERTC_PC_LOAD] | load_pin_s; // [R13]
    wire latch_lvl = pattern_control_r[`BERTC_PC_LATCH] | latch_pin_s; // [R2]
    wire rxl_lvl = pattern_control_r[`BERTC_PC_RXLATCH] | rxl_pin_s;
    wire load_rise = load_lvl & ~load_prev_r; // [R13]
    wire latch_rise = latch_lvl & ~latch_prev_r; // [R2]
    wire rxl_rise = rxl_lvl & ~rxl_prev_r;
    wire resync_rise = pattern_control_r[`BERTC_PC_RESYNC] & ~resync_prev_r; // [R14]
    wire single_rise = error_insertion_r[`BERTC_EI_SINGLE] & ~single_prev_r; // [R5]

    // decoded settings
    wire prbs_mode = pattern_control_r[`BERTC_PC_PRBS];
    wire zero_sup = pattern_control_r[`BERTC_PC_ZSUP]; // [R12]
    wire auto_sync = pattern_control_r[`BERTC_PC_AUTOSYNC];
    wire loopback = pattern_control_r[`BERTC_PC_LOOP];
    wire [2:0] rate_sel = error_insertion_r[`BERTC_EI_RATE_MSB:`BERTC_EI_RATE_LSB];

    // generator next value and output bit
    wire gen_fb = prbs_mode ? (bit_at(gen_r, pattern_length) ^ bit_at(gen_r, tap_select))
                            : bit_at(gen_r, pattern_length); // [R11]
    wire gen_raw = bit_at(gen_r, pattern_length);
    wire gen_bit = gen_raw | (zero_sup & (zrun_r == `BERTC_ZERO_RUN)); // [R12]

    // decade dividers, carry k pulses once per ten to the k cycles
    assign carry[0] = 1'b1;
    genvar gi;
    generate
        for (gi = 0; gi < `BERTC_DECADE_STAGES; gi = gi + 1) begin : g_decade
            reg [3:0] dec_r;
            assign carry[gi + 1] = carry[gi] & (dec_r == `BERTC_DECADE_LAST);
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    dec_r <= 4'h0;
                end else if (carry[gi]) begin
                    dec_r <= (dec_r == `BERTC_DECADE_LAST) ? 4'h0 : dec_r + 4'h1;
                end
            end
        end
    endgenerate

    // automatic and single error requests
    wire auto_err = (rate_sel != 3'h0) & carry[rate_sel]; // [R3] [R10]
    wire inject = auto_err | single_rise; // [R4]

    // receive path with loopback and inversion
    wire rx_in = loopback ? tx_data : rx_pin_s;
    wire rx_bit = rx_in ^ error_insertion_r[`BERTC_EI_RXINV]; // [R7]
    wire predicted = prbs_mode ? (bit_at(rxsr_r, pattern_length) ^ bit_at(rxsr_r, tap_select))
                               : bit_at(rxsr_r, pattern_length);
    wire mismatch = rx_bit ^ predicted;
    wire locked = (state_r == ST_LOCK);

    assign in_sync = locked;

    // host register writes
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pattern_control_r <= `BERTC_RESET_BYTE;
            error_insertion_r <= 6'h00;
        end else if (wr_en) begin
            if (addr == `BERTC_ADDR_PATTERN) begin
                pattern_control_r <= wr_data; // [R9]
            end
            if (addr == `BERTC_ADDR_ERRINS) begin
                error_insertion_r <= wr_data[5:0]; // [R8]
            end
        end
    end

    // host register reads, unmapped reads zero
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data <= `BERTC_RESET_BYTE;
        end else if (rd_en) begin
            case (addr)
                `BERTC_ADDR_PATTERN: rd_data <= pattern_control_r;
                `BERTC_ADDR_ERRINS: rd_data <= {2'b00, error_insertion_r};
                default: rd_data <= `BERTC_RESET_BYTE;
            endcase
        end
    end

    // edge detector history
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            load_prev_r <= 1'b0;
            latch_prev_r <= 1'b0;
            rxl_prev_r <= 1'b0;
            resync_prev_r <= 1'b0;
            single_prev_r <= 1'b0;
        end else begin
            load_prev_r <= load_lvl;
            latch_prev_r <= latch_lvl;
            rxl_prev_r <= rxl_lvl;
            resync_prev_r <= pattern_control_r[`BERTC_PC_RESYNC];
            single_prev_r <= error_insertion_r[`BERTC_EI_SINGLE];
        end
    end

    // pattern generator and transmit bit
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            gen_r <= 32'h00000000;
            zrun_r <= 4'h0;
            tx_data <= 1'b0;
        end else begin
            if (load_rise) begin
                gen_r <= pattern_seed; // [R13]
                zrun_r <= 4'h0;
            end else begin
                gen_r <= {gen_r[30:0], gen_fb}; // [R11]
                if (gen_bit) begin
                    zrun_r <= 4'h0;
                end else if (zrun_r != `BERTC_ZERO_RUN) begin
                    zrun_r <= zrun_r + 4'h1;
                end
            end
            tx_data <= gen_bit ^ inject ^ error_insertion_r[`BERTC_EI_TXINV]; // [R5] [R6]
        end
    end

    // receive shift register and capture
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rxsr_r <= 32'h00000000;
            pattern_receive <= 32'h00000000;
        end else begin
            rxsr_r <= {rxsr_r[30:0], rx_bit};
            if (rxl_rise) begin
                pattern_receive <= rxsr_r;
            end
        end
    end

    // synchronizer: hunt for a run of matches, drop on too many errors
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= ST_HUNT;
            match_r <= 6'h00;
            win_r <= 6'h00;
            win_err_r <= 4'h0;
        end else if (resync_rise) begin
            state_r <= ST_HUNT; // [R14]
            match_r <= 6'h00;
        end else begin
            case (state_r)
                ST_HUNT: begin
                    match_r <= mismatch ? 6'h00 : match_r + 6'h01;
                    win_r <= 6'h00;
                    win_err_r <= 4'h0;
                    if (!mismatch && (match_r == `BERTC_SYNC_MATCHES - 6'h01)) begin
                        state_r <= ST_LOCK;
                    end
                end
                ST_LOCK: begin
                    win_r <= win_r + 6'h01;
                    if (win_r == `BERTC_LOSS_WINDOW_END) begin
                        win_err_r <= 4'h0;
                        if (auto_sync && (win_err_r >= `BERTC_LOSS_ERRORS)) begin
                            state_r <= ST_HUNT; // [R14]
                            match_r <= 6'h00;
                        end
                    end else if (mismatch && (win_err_r != 4'hF)) begin
                        win_err_r <= win_err_r + 4'h1;
                    end
                end
                default: begin
                    state_r <= ST_HUNT;
                    match_r <= 6'h00;
                end
            endcase
        end
    end

    // bit and error counters with latch into readable counts
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            bitcnt_r <= 32'h00000000;
            errcnt_r <= 32'h00000000;
            bit_count <= 32'h00000000;
            error_count <= 32'h00000000;
        end else if (latch_rise) begin
            bit_count <= bitcnt_r; // [R1]
            error_count <= errcnt_r; // [R1]
            bitcnt_r <= 32'h00000000;
            errcnt_r <= 32'h00000000;
        end else if (locked) begin
            bitcnt_r <= bitcnt_r + 32'h00000001;
            if (mismatch) begin
                errcnt_r <= errcnt_r + 32'h00000001;
            end
        end
    end

endmodule

`default_nettype wire

// >>> rtl/bertc_consts.vh
`ifndef BERTC_CONSTS_VH
`define BERTC_CONSTS_VH

// host register addresses
`define BERTC_ADDR_PATTERN 4'h6
`define BERTC_ADDR_ERRINS 4'h7
`define BERTC_RESET_BYTE 8'h00

// pattern control bit positions
`define BERTC_PC_LOAD 7
`define BERTC_PC_ZSUP 6
`define BERTC_PC_PRBS 5
`define BERTC_PC_LATCH 4
`define BERTC_PC_RXLATCH 3
`define BERTC_PC_AUTOSYNC 2
`define BERTC_PC_RESYNC 1
`define BERTC_PC_LOOP 0

// error insertion bit positions
`define BERTC_EI_TXINV 5
`define BERTC_EI_RXINV 4
`define BERTC_EI_SINGLE 3
`define BERTC_EI_RATE_MSB 2
`define BERTC_EI_RATE_LSB 0

// error rate decade divider
`define BERTC_DECADE_LAST 4'h9
`define BERTC_DECADE_STAGES 7

// synchronizer thresholds
`define BERTC_SYNC_MATCHES 6'h20
`define BERTC_LOSS_WINDOW_END 6'h3F
`define BERTC_LOSS_ERRORS 4'h6

// zero suppression run length
`define BERTC_ZERO_RUN 4'hE

`endif

// >>> rtl/bertc_pin_sync.v
`default_nettype none

module bertc_pin_sync (
    // clock and reset
    input wire clock,
    input wire rst,
    // asynchronous pin and its filtered level
    input wire pin,
    output reg level
);

    reg s1_r;
    reg s2_r;
    reg s3_r;

    // three stages; level follows once stages two and three agree
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level <= s3_r;
            end
        end
    end

endmodule

`default_nettype wire

// >>> sim/bertc_ctrl_assertions.sv
`default_nettype none
module bertc_ctrl_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // host port
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    // latch pin and results
    input wire logic latch_counts_pin,
    input wire logic [31:0] bit_count,
    input wire logic [31:0] error_count,
    input wire logic in_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic [5:0] age_r;
    logic [3:0] quiet_r;
    // cycles since reset and since the last latch request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            age_r <= 6'h00;
            quiet_r <= 4'h0;
        end else begin
            if (age_r != 6'h3F) age_r <= age_r + 6'h01;
            if (latch_counts_pin || (wr_en && addr == 4'h6 && wr_data[4])) quiet_r <= 4'h0;
            else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
        end
    end
    sequence s_wr(a); wr_en && addr == a; endsequence
    sequence s_rd(a); rd_en && !wr_en && addr == a; endsequence
    a_unmapped_zero:
        assert property (rd_en && addr != 4'h6 && addr != 4'h7 |=> rd_data == 8'h00) else $error("unmapped read");
    a_read_hold:
        assert property (!rd_en |=> $stable(rd_data)) else $error("read data moved");
    a_errins_back:
        assert property (s_wr(4'h7) ##1 s_rd(4'h7) |=> rd_data == {2'b00, $past(wr_data[5:0], 2)})
        else $error("error insertion readback");
    a_pattern_back:
        assert property (s_wr(4'h6) ##1 s_rd(4'h6) |=> rd_data == $past(wr_data, 2)) else $error("pattern readback");
    a_reset_clear:
        assert property ($fell(rst) |-> bit_count == 0 && error_count == 0 && !in_sync) else $error("reset state");
    a_lock_delay:
        assert property (in_sync |-> age_r >= 6'h20) else $error("lock too early");
    a_err_le_bits:
        assert property (error_count <= bit_count) else $error("errors above bits");
    a_count_quiet:
        assert property (quiet_r == 4'hF |-> $stable(bit_count) && $stable(error_count)) else $error("count moved");
endmodule
bind bertc_ctrl bertc_ctrl_chk chk (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .latch_counts_pin(latch_counts_pin), .bit_count(bit_count),
    .error_count(error_count), .in_sync(in_sync));
`default_nettype wire

// >>> sim/bertc_eut_model.sv
`default_nettype none
module bertc_eut_model (
    // line side
    input wire logic clock,
    input wire logic tx_data,
    output var logic rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rx_data = 1'b0;
    // equipment loops the line back one bit later
    always @(posedge clock) rx_data <= tx_data;
endmodule
`default_nettype wire

// >>> sim/bertc_ctrl_bench.sv
`default_nettype none
module bertc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic latch_counts_pin = 1'b0;
    logic load_pin = 1'b0;
    logic rxl_pin = 1'b0;
    logic [31:0] pattern_seed = 32'hFFFFFFFF;
    logic [4:0] pattern_length = 5'h00;
    logic [4:0] tap_select = 5'h00;
    wire [7:0] rd_data;
    wire tx_data, rx_data, in_sync;
    wire [31:0] bit_count, error_count, pattern_receive;
    integer err_count = 0, check_count = 0, seed = 32'h33be, zcnt, i;
    logic [7:0] d;
    always #4 clock = ~clock;
    bertc_ctrl dut (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .load_pattern_pin(load_pin), .latch_counts_pin(latch_counts_pin), .rx_latch_pin(rxl_pin),
        .tx_data(tx_data), .rx_data_pin(rx_data), .pattern_seed(pattern_seed), .pattern_length(pattern_length),
        .tap_select(tap_select), .bit_count(bit_count), .error_count(error_count), .pattern_receive(pattern_receive),
        .in_sync(in_sync));
    bertc_eut_model eut (.clock(clock), .tx_data(tx_data), .rx_data(rx_data));
    function automatic logic [7:0] exp_reg(input logic [3:0] a, input logic [7:0] v);
        return (a == 4'h7) ? {2'b00, v[5:0]} : v;
    endfunction
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // host bus cycles, entered at a falling edge
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        addr = a;
        wr_data = v;
        wr_en = 1'b1;
        @(negedge clock) wr_en = 1'b0;
        @(negedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        addr = a;
        rd_en = 1'b1;
        @(negedge clock) rd_en = 1'b0;
        check_val(rd_data, e);
        @(negedge clock);
    endtask
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] v);
        addr = a;
        wr_data = v;
        wr_en = 1'b1;
        @(negedge clock) wr_en = 1'b0;
        rd(a, exp_reg(a, v));
    endtask
    task automatic zeros(input integer n);
        zcnt = 0;
        repeat (n) @(posedge clock) #1 if (tx_data === 1'b0) zcnt++;
        @(negedge clock);
    endtask
    // write, then count zeros from the first edge the write can reach
    task automatic wr_zeros(input logic [3:0] a, input logic [7:0] v, input integer n);
        addr = a;
        wr_data = v;
        wr_en = 1'b1;
        @(negedge clock) wr_en = 1'b0;
        zeros(n);
    endtask
    // expected zero-suppressed pseudorandom stream, checked bit by bit
    task automatic zero_suppression_select_run(input integer n);
        logic [31:0] g;
        integer zr;
        logic b;
        g = pattern_seed;
        zr = 0;
        repeat (n) begin
            @(posedge clock) #1;
            b = g[pattern_length] | (zr == 14);
            zr = b ? 0 : zr + 1;
            g = {g[30:0], g[pattern_length] ^ g[tap_select]};
            check_val(tx_data, b);
        end
        @(negedge clock);
    endtask
    task automatic wait_lock;
        for (int k = 0; k < 400 && in_sync !== 1'b1; k++) @(negedge clock);
    endtask
    // main sequence
    initial begin
        repeat (3) @(negedge clock);
        rst = 1'b0;
        rd(4'h6, 8'h00);
        rd(4'h7, 8'h00);
        rd(4'h3, 8'h00);
        wr_rd(4'h7, 8'h3F);
        for (i = 0; i < 12; i++) begin
            d = 8'($random(seed));
            wr_rd(4'h6 + {3'h0, d[0]}, d & (d[0] ? 8'h3F : 8'hFF));
        end
        wr(4'h6, 8'h00);
        wr(4'h7, 8'h00);
        wr(4'h6, 8'h80);
        wr(4'h6, 8'h00);
        zeros(50);
        check_val(zcnt, 0);
        rxl_pin = 1'b1;
        repeat (8) @(negedge clock);
        rxl_pin = 1'b0;
        check_val(pattern_receive, 32'hFFFFFFFF);
        wr_zeros(4'h7, 8'h20, 50);
        check_val(zcnt, 50);
        rxl_pin = 1'b1;
        repeat (8) @(negedge clock);
        rxl_pin = 1'b0;
        check_val(pattern_receive, 32'h00000000);
        wr_zeros(4'h7, 8'h08, 50);
        check_val(zcnt, 1);
        wr_zeros(4'h7, 8'h08, 50);
        check_val(zcnt, 0);
        for (i = 0; i < 4; i++) begin
            wr(4'h7, i[7:0]);
            zeros(20);
            zeros(i == 0 ? 100 : 10 * 10 ** i);
            check_val(zcnt, i == 0 ? 0 : 10);
        end
        pattern_length = 5'h13;
        tap_select = 5'h02;
        wr(4'h7, 8'h30);
        wr(4'h6, 8'h26);
        load_pin = 1'b1;
        repeat (8) @(negedge clock);
        load_pin = 1'b0;
        wr(4'h6, 8'h24);
        wait_lock;
        check_val(in_sync, 1);
        latch_counts_pin = 1'b1;
        repeat (8) @(negedge clock);
        latch_counts_pin = 1'b0;
        repeat (60) @(negedge clock);
        wr(4'h6, 8'h34);
        repeat (10) @(negedge clock);
        check_val(error_count, 0);
        check_val(bit_count > 60, 1);
        wr(4'h7, 8'h38);
        repeat (40) @(negedge clock);
        wr(4'h6, 8'h24);
        wr(4'h6, 8'h34);
        repeat (4) @(negedge clock);
        check_val(error_count, 3);
        wr(4'h6, 8'h37);
        @(negedge clock);
        check_val(in_sync, 0);
        wait_lock;
        check_val(in_sync, 1);
        pattern_length = 5'h13;
        tap_select = 5'h10;
        wr(4'h7, 8'h00);
        wr(4'h6, 8'hE0);
        zero_suppression_select_run(3000);
        close_out;
    end
    // stop a hung run
    initial begin
        #200000;
        err_count++;
        close_out;
    end
endmodule
`default_nettype wire
